/* File: logic/nts_pkg.sv */
// shared constants and types for the negotiation and training sequencer control block
package nts_pkg;

    // register word offsets on the reconfiguration port
    localparam logic [15:0] OFS_SEQ_CONFIG = 16'h00B0;
    localparam logic [15:0] OFS_SEQ_STATE = 16'h00B1;
    localparam logic [15:0] OFS_NEG_CONFIG_FIRST = 16'h00C0;
    localparam logic [15:0] OFS_NEG_CONFIG_SECOND = 16'h00C1;

    // sequencer_config field positions
    localparam int CFG_HALT_REQ = 31;
    localparam int CFG_RXINV_LSB = 26;
    localparam int CFG_TXINV_LSB = 22;
    localparam int CFG_RSFEC_REQ = 21;
    localparam int CFG_RSFEC_EN = 20;
    localparam int CFG_LPBK_LSB = 16;
    localparam int CFG_BYPASS_TRAIN = 14;
    localparam int CFG_FAIL_ON_HIBER = 13;
    localparam int CFG_TRAIN_FAIL_ACT = 12;
    localparam int CFG_FORCE_FEC = 7;
    localparam int CFG_FORCE_LSB = 4;
    localparam int CFG_INHIBIT_OFF = 2;
    localparam int CFG_NEG_TIMER_OFF = 1;
    localparam int CFG_SEQ_RESET = 0;
    localparam logic [31:0] CFG_WMASK = 32'hBFFF_70F6;
    localparam logic [31:0] CFG_RESET = 32'h0000_2002;

    // sequencer_state field positions
    localparam int ST_HALTED = 31;
    localparam int ST_FEC_ABILITY = 18;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_TRAIN_TO = 2;
    localparam int ST_NEG_TO = 1;
    localparam int ST_READY = 0;

    // negotiation_config_first field positions
    localparam int NCF_OUI_LSB = 16;
    localparam int NCF_ANY_UNFMT = 11;
    localparam int NCF_NP_OVERRIDE = 10;
    localparam int NCF_CONS_RX = 9;
    localparam int NCF_CONS_TX = 8;
    localparam int NCF_IGN_NONCE = 7;
    localparam int NCF_CHAN_OVR = 6;
    localparam int NCF_PARAM_OVR = 5;
    localparam int NCF_RFAULT = 3;
    localparam int NCF_USER_NP = 2;
    localparam int NCF_USER_BP = 1;
    localparam int NCF_NEG_EN = 0;
    localparam logic [31:0] NCF_WMASK = 32'hFFFF_0FEF;
    localparam logic [31:0] NCF_RESET = 32'h0000_0201;
    localparam int NCS_HANDOFF = 8;

    // consortium next page code expected unless any page is accepted
    localparam logic [8:0] CONS_NP_CODE = 9'h003;

    // protocol codes, shared by forced mode and negotiation result
    localparam logic [2:0] PROTO_NONE = 3'h0;
    localparam logic [2:0] PROTO_25G = 3'h1;
    localparam logic [2:0] PROTO_100G_R4 = 3'h4;
    localparam logic [2:0] PROTO_10G = 3'h5;
    localparam logic [2:0] PROTO_100G_P2 = 3'h7;

    // stage bits inside the one-hot mode field
    localparam int MODE_NEG = 0;
    localparam int MODE_TRAIN = 1;
    localparam int MODE_10G = 2;
    localparam int MODE_25G = 3;
    localparam int MODE_R4 = 5;
    localparam int MODE_P2 = 7;

    // negotiation timeout, about one second at the system clock
    localparam int SYS_CLK_KHZ = 40000;
    localparam int NEG_TIMEOUT_MS = 1000;
    localparam int NEG_TIMEOUT_CYCLES = NEG_TIMEOUT_MS * SYS_CLK_KHZ;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_NEG, SEQ_TRAIN, SEQ_DATA} nts_seq_type;

    // one access on the reconfiguration port, word addressed
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } nts_req_type;

    // events and levels from the negotiation, training and pcs engines
    typedef struct packed {
        logic neg_done;
        logic [2:0] neg_proto;
        logic train_done;
        logic train_fail;
        logic train_timeout;
        logic pcs_hiber;
        logic pcs_link_up;
        logic np_exchanged;
    } nts_link_type;

    // controls handed to the negotiation engine
    typedef struct packed {
        logic enable;
        logic any_unformatted;
        logic [8:0] cons_np_code;
        logic cons_np_override;
        logic cons_np_receive;
        logic cons_np_send;
        logic ignore_nonce;
        logic chan_override;
        logic param_override;
        logic remote_fault;
        logic user_np_enable;
        logic user_bp_enable;
        logic [15:0] oui;
        logic rsfec_request;
        logic rsfec_enable;
    } nts_neg_ctrl_type;

endpackage : nts_pkg

/* File: logic/nts_timeout.sv */
// restartable cycle timer giving a one-cycle expiry pulse
`timescale 1ns/100ps
`default_nettype none
module nts_timeout #(
    parameter int unsigned CYCLES = 16
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_start,
    input wire logic i_run,
    // result
    output logic o_expired
);
    typedef struct packed {
        logic [31:0] count;
        logic armed;
        logic expired;
    } nts_tmr_type;

    nts_tmr_type r;
    nts_tmr_type next_r;

    // counts only while running, so a halt freezes the remaining time
    always_comb begin
        next_r = r;
        next_r.expired = 1'b0;
        if (i_start) begin
            next_r.count = 32'h0000_0000;
            next_r.armed = 1'b1;
        end else if (i_run && r.armed) begin
            if (r.count == CYCLES - 1) begin
                next_r.expired = 1'b1;
                next_r.armed = 1'b0;
            end else begin
                next_r.count = r.count + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_expired = r.expired;
endmodule : nts_timeout
`default_nettype wire

/* File: logic/nts_seq_ctrl.sv */
// sequencer config, status and first negotiation config registers with the sequencer
// Function
// - halt request bit 31 freezes the sequencer; status bit 31 reports halted
// - per-lane rx and tx polarity inversion; tx latched at training restart
// - bit 21 requests RS-FEC, bit 20 enables RS-FEC negotiation
// - per-lane internal loopback from bits 19:16, latched at training restart
// - bit 14 skips training after negotiation timeout and goes to data
// - bit 13 makes high bit error rate in data mode a link failure
// - bit 12 picks data mode or restart after a training failure
// - bits 6:4 force a protocol; bit 7 forces RS-FEC where capable
// - negotiation and training still run while a protocol is forced
// - bit 2 clear restarts negotiation, or training if negotiation is off, on link loss; set stays in data
// - bit 1 clear lets negotiation time out and try another protocol
// - writing bit 0 restarts the sequencer; the bit is not stored and always reads back zero
// - status bit 18 shows local RS-FEC ability
// - status bits 15:8 show the current stage one-hot
// - sticky training and negotiation timeout flags, each cleared when its own stage next restarts
// - status bit 0 shows link ready for data mode
// - bit 11 accepts any unformatted page, else only code 0x003
// - bit 8 sends consortium pages, bit 9 decodes received ones
// - bit 7 ignores the nonce field; reset differs for simulation
// - bit 2 makes next pages stall for the handoff bit
// - bit 0 of the negotiation config enables negotiation
// - registers sit on a word addressed 32-bit reconfiguration port
// - handoff bit clears itself once the page exchange completes
`timescale 1ns/100ps
`default_nettype none
module nts_seq_ctrl
    import nts_pkg::*;
#(
    parameter int unsigned NEG_TIMEOUT = NEG_TIMEOUT_CYCLES,
    parameter bit REQUEST_RSFEC = 1'b0,
    parameter bit ENABLE_RSFEC = 1'b0,
    parameter bit SIM_MODE = 1'b0,
    parameter logic [1:0] CURRENT_LANE = 2'h0,
    parameter logic [15:0] OUI_RESET = 16'h1234, // arbitrary value
    parameter logic [2:0] DEFAULT_PROTO = PROTO_25G
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // reconfiguration port
    input wire nts_req_type i_cfg_req,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // engine events
    input wire nts_link_type i_link,
    // lane controls
    output logic [3:0] o_rx_invert,
    output logic [3:0] o_tx_invert,
    output logic [3:0] o_loopback,
    output logic o_force_rsfec,
    // sequencer outputs
    output nts_neg_ctrl_type o_neg_ctrl,
    output logic o_neg_restart,
    output logic o_train_restart,
    output logic [2:0] o_proto,
    output logic [7:0] o_stage,
    output logic o_link_ready,
    output logic o_np_handoff,
    output logic o_halted
);
    typedef struct packed {
        nts_seq_type seq;
        logic [31:0] cfg;
        logic seq_reset;
        logic [31:0] ncf;
        logic handoff;
        logic [2:0] proto;
        logic [3:0] tx_inv;
        logic [3:0] lpbk;
        logic neg_to;
        logic train_to;
        logic halted;
        logic neg_restart;
        logic train_restart;
        logic [31:0] rdata;
        logic rvalid;
    } nts_state_type;

    localparam logic [31:0] CFG_RESET_FULL = CFG_RESET
        | (32'(REQUEST_RSFEC) << CFG_RSFEC_REQ)
        | (32'(ENABLE_RSFEC) << CFG_RSFEC_EN);
    localparam logic [31:0] NCF_RESET_FULL = NCF_RESET
        | (32'(OUI_RESET) << NCF_OUI_LSB)
        | (32'(SIM_MODE) << NCF_IGN_NONCE);

    nts_state_type r;
    nts_state_type next_r;
    logic tmr_expired;

    // lanes a protocol drives: four for nrz, 2 and 0 for pam4, else own lane
    function automatic logic [3:0] lane_mask(input logic [2:0] proto);
        logic [3:0] m;
        m = 4'h0;
        if (proto == PROTO_100G_R4) begin
            m = 4'hF;
        end else if (proto == PROTO_100G_P2) begin
            m = 4'h5;
        end else begin
            m[CURRENT_LANE] = 1'b1;
        end
        return m;
    endfunction : lane_mask

    // candidate order after a negotiation timeout
    function automatic logic [2:0] next_proto(input logic [2:0] proto);
        logic [2:0] p;
        p = PROTO_25G;
        unique case (proto)
            PROTO_25G: p = PROTO_10G;
            PROTO_10G: p = PROTO_100G_R4;
            PROTO_100G_R4: p = PROTO_100G_P2;
            default: p = PROTO_25G;
        endcase
        return p;
    endfunction : next_proto

    // one-hot stage from sequencer state and protocol
    function automatic logic [7:0] stage_of(input nts_seq_type seq, input logic [2:0] proto);
        logic [7:0] s;
        s = 8'h00;
        unique case (seq)
            SEQ_IDLE: s = 8'h00;
            SEQ_NEG: s[MODE_NEG] = 1'b1;
            SEQ_TRAIN: s[MODE_TRAIN] = 1'b1;
            SEQ_DATA: begin
                if (proto == PROTO_10G) s[MODE_10G] = 1'b1;
                else if (proto == PROTO_100G_R4) s[MODE_R4] = 1'b1;
                else if (proto == PROTO_100G_P2) s[MODE_P2] = 1'b1;
                else s[MODE_25G] = 1'b1;
            end
        endcase
        return s;
    endfunction : stage_of

    // negotiation timer runs only in the negotiation stage and not while halted
    nts_timeout #(
        .CYCLES(NEG_TIMEOUT)
    ) u_neg_timer (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(r.neg_restart),
        .i_run(r.seq == SEQ_NEG && !r.halted && !r.cfg[CFG_NEG_TIMER_OFF]),
        .o_expired(tmr_expired)
    );

    // register access, sequencer stepping and flag upkeep
    always_comb begin
        logic want_neg;
        logic want_train;
        logic neg_en;
        logic [2:0] forced;
        logic [31:0] status;
        want_neg = 1'b0;
        want_train = 1'b0;
        neg_en = r.ncf[NCF_NEG_EN];
        forced = r.cfg[CFG_FORCE_LSB +: 3];
        status = 32'h0000_0000;
        next_r = r;
        next_r.neg_restart = 1'b0;
        next_r.train_restart = 1'b0;
        next_r.rvalid = 1'b0;
        next_r.halted = r.cfg[CFG_HALT_REQ];

        // sequencer stepping; a restart request overrides a halt
        if (r.seq_reset) begin
            next_r.seq = SEQ_IDLE;
            if (r.seq == SEQ_IDLE) begin
                next_r.seq_reset = 1'b0;
            end
        end else if (!r.halted) begin
            unique case (r.seq)
                SEQ_IDLE: begin
                    if (forced != PROTO_NONE) next_r.proto = forced;
                    if (neg_en) want_neg = 1'b1;
                    else want_train = 1'b1;
                end
                SEQ_NEG: begin
                    if (!neg_en) begin
                        want_train = 1'b1;
                    end else if (i_link.neg_done) begin
                        // a forced protocol beats the outcome, the stages still run
                        next_r.proto = (forced != PROTO_NONE) ? forced : i_link.neg_proto;
                        want_train = 1'b1;
                    end else if (tmr_expired) begin
                        next_r.neg_to = 1'b1;
                        if (forced == PROTO_NONE) next_r.proto = next_proto(r.proto);
                        if (r.cfg[CFG_BYPASS_TRAIN]) next_r.seq = SEQ_DATA;
                        else want_train = 1'b1;
                    end
                end
                SEQ_TRAIN: begin
                    if (i_link.train_done) begin
                        next_r.seq = SEQ_DATA;
                    end else if (i_link.train_fail || i_link.train_timeout) begin
                        if (i_link.train_timeout) next_r.train_to = 1'b1;
                        if (r.cfg[CFG_TRAIN_FAIL_ACT]) next_r.seq = SEQ_DATA;
                        else if (neg_en) want_neg = 1'b1;
                        else want_train = 1'b1;
                    end
                end
                SEQ_DATA: begin
                    // inhibit timer off keeps data mode on link loss until reset or software
                    if ((i_link.pcs_hiber && r.cfg[CFG_FAIL_ON_HIBER])
                        || (!i_link.pcs_link_up && !r.cfg[CFG_INHIBIT_OFF])) begin
                        if (neg_en) want_neg = 1'b1;
                        else want_train = 1'b1;
                    end
                end
            endcase
        end

        // stage entry actions
        if (want_neg) begin
            next_r.seq = SEQ_NEG;
            next_r.neg_restart = 1'b1;
            next_r.neg_to = 1'b0;
        end
        if (want_train) begin
            next_r.seq = SEQ_TRAIN;
            next_r.train_restart = 1'b1;
            next_r.train_to = 1'b0;
            // tx polarity and loopback only change at a training restart
            next_r.tx_inv = r.cfg[CFG_TXINV_LSB +: 4] & lane_mask(next_r.proto);
            next_r.lpbk = r.cfg[CFG_LPBK_LSB +: 4] & lane_mask(next_r.proto);
        end

        // handoff clears on exchange; a write in the same cycle wins
        if (i_link.np_exchanged) next_r.handoff = 1'b0;

        // register writes, masked so read-only and reserved bits hold
        if (i_cfg_req.wr) begin
            unique case (i_cfg_req.addr)
                OFS_SEQ_CONFIG: begin
                    next_r.cfg = (i_cfg_req.wdata & CFG_WMASK) | (r.cfg & ~CFG_WMASK);
                    if (i_cfg_req.wdata[CFG_SEQ_RESET]) next_r.seq_reset = 1'b1;
                end
                OFS_NEG_CONFIG_FIRST: begin
                    next_r.ncf = (i_cfg_req.wdata & NCF_WMASK) | (r.ncf & ~NCF_WMASK);
                end
                OFS_NEG_CONFIG_SECOND: begin
                    if (i_cfg_req.wdata[NCS_HANDOFF] && r.ncf[NCF_USER_NP]) begin
                        next_r.handoff = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // status word assembly
        status[ST_HALTED] = r.halted;
        status[ST_FEC_ABILITY] = ENABLE_RSFEC;
        status[ST_MODE_LSB +: 8] = stage_of(r.seq, r.proto);
        status[ST_TRAIN_TO] = r.train_to;
        status[ST_NEG_TO] = r.neg_to;
        status[ST_READY] = (r.seq == SEQ_DATA);

        // reads answer one cycle later; unmapped words read zero
        if (i_cfg_req.rd) begin
            next_r.rvalid = 1'b1;
            unique case (i_cfg_req.addr)
                OFS_SEQ_CONFIG: next_r.rdata = r.cfg;
                OFS_SEQ_STATE: next_r.rdata = status;
                OFS_NEG_CONFIG_FIRST: next_r.rdata = r.ncf;
                OFS_NEG_CONFIG_SECOND: next_r.rdata = 32'(r.handoff) << NCS_HANDOFF;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            r <= '0;
            r.seq <= SEQ_IDLE;
            r.cfg <= CFG_RESET_FULL;
            r.ncf <= NCF_RESET_FULL;
            r.proto <= DEFAULT_PROTO;
        end else begin
            r <= next_r;
        end
    end

    // register port answer
    assign o_cfg_rdata = r.rdata;
    assign o_cfg_rvalid = r.rvalid;

    // lane controls; rx follows the register, tx and loopback the latched copy
    assign o_rx_invert = r.cfg[CFG_RXINV_LSB +: 4] & lane_mask(r.proto);
    assign o_tx_invert = r.tx_inv;
    assign o_loopback = r.lpbk;
    // 10g never carries rs-fec, 100g-p2 always does
    assign o_force_rsfec = (r.proto == PROTO_100G_P2)
        || (r.cfg[CFG_FORCE_FEC] && r.proto != PROTO_10G);

    // negotiation engine controls
    assign o_neg_ctrl.enable = r.ncf[NCF_NEG_EN];
    assign o_neg_ctrl.any_unformatted = r.ncf[NCF_ANY_UNFMT];
    assign o_neg_ctrl.cons_np_code = CONS_NP_CODE;
    assign o_neg_ctrl.cons_np_override = r.ncf[NCF_NP_OVERRIDE];
    assign o_neg_ctrl.cons_np_receive = r.ncf[NCF_CONS_RX];
    assign o_neg_ctrl.cons_np_send = r.ncf[NCF_CONS_TX];
    assign o_neg_ctrl.ignore_nonce = r.ncf[NCF_IGN_NONCE];
    assign o_neg_ctrl.chan_override = r.ncf[NCF_CHAN_OVR];
    assign o_neg_ctrl.param_override = r.ncf[NCF_PARAM_OVR];
    assign o_neg_ctrl.remote_fault = r.ncf[NCF_RFAULT];
    assign o_neg_ctrl.user_np_enable = r.ncf[NCF_USER_NP];
    assign o_neg_ctrl.user_bp_enable = r.ncf[NCF_USER_BP];
    assign o_neg_ctrl.oui = r.ncf[NCF_OUI_LSB +: 16];
    assign o_neg_ctrl.rsfec_request = r.cfg[CFG_RSFEC_REQ];
    assign o_neg_ctrl.rsfec_enable = r.cfg[CFG_RSFEC_EN];

    // sequencer outputs
    assign o_neg_restart = r.neg_restart;
    assign o_train_restart = r.train_restart;
    assign o_proto = r.proto;
    assign o_stage = stage_of(r.seq, r.proto);
    assign o_link_ready = (r.seq == SEQ_DATA);
    assign o_np_handoff = r.handoff;
    assign o_halted = r.halted;
endmodule : nts_seq_ctrl
`default_nettype wire

/* File: dv/nts_seq_ctrl_checker.sv */
// concurrent checks on the sequencer control block ports
`timescale 1ns/100ps
`default_nettype none
module nts_seq_ctrl_checker
    import nts_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // watched ports
    input wire nts_req_type i_cfg_req,
    input wire nts_link_type i_link,
    input wire logic o_cfg_rvalid,
    input wire logic o_neg_restart,
    input wire logic o_train_restart,
    input wire logic [7:0] o_stage,
    input wire logic o_link_ready,
    input wire logic o_np_handoff,
    input wire logic o_halted
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // event steps; a write may carry a sequencer reset that acts a cycle on, so it is kept out
    sequence s_neg_done;
        o_stage[MODE_NEG] && i_link.neg_done && !o_halted && !i_cfg_req.wr
            && !$past(i_cfg_req.wr);
    endsequence
    sequence s_enter_train;
        o_stage[MODE_TRAIN] && o_train_restart;
    endsequence
    AST_RVALID: assert property (o_cfg_rvalid == $past(i_cfg_req.rd))
        else $error("read answer not one cycle after strobe");
    AST_ONEHOT: assert property ($onehot0(o_stage) && !o_stage[4] && !o_stage[6])
        else $error("stage field not one-hot");
    AST_READY: assert property (o_link_ready == |{o_stage[7], o_stage[5], o_stage[3:2]})
        else $error("link ready differs from data stage");
    AST_NEG_ENTRY: assert property ($rose(o_stage[MODE_NEG]) |-> o_neg_restart)
        else $error("negotiation entered without restart pulse");
    AST_TO_TRAIN: assert property (s_neg_done |=> s_enter_train)
        else $error("negotiation done did not start training");
    AST_TO_DATA: assert property (o_stage[MODE_TRAIN] && i_link.train_done
        && !i_link.train_fail && !o_halted && !i_cfg_req.wr && !$past(i_cfg_req.wr)
        |=> o_link_ready)
        else $error("training done did not reach data mode");
    AST_HANDOFF: assert property (o_np_handoff && i_link.np_exchanged && !i_cfg_req.wr
        |=> !o_np_handoff)
        else $error("handoff bit did not clear");
    // halted stage freezes; recent writes excluded since reset acts through halt
    AST_HALT_FREEZE: assert property (o_halted && !i_cfg_req.wr && !$past(i_cfg_req.wr)
        && !$past(i_cfg_req.wr, 2) && !$past(i_cfg_req.wr, 3) |=> $stable(o_stage))
        else $error("stage moved while halted");
endmodule : nts_seq_ctrl_checker
bind nts_seq_ctrl nts_seq_ctrl_checker i_checker (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_cfg_req(i_cfg_req), .i_link(i_link),
    .o_cfg_rvalid(o_cfg_rvalid), .o_neg_restart(o_neg_restart),
    .o_train_restart(o_train_restart), .o_stage(o_stage), .o_link_ready(o_link_ready),
    .o_np_handoff(o_np_handoff), .o_halted(o_halted));
`default_nettype wire

/* File: dv/nts_link_model.sv */
// stand-in for the negotiation, training and pcs engines
`timescale 1ns/100ps
`default_nettype none
module nts_link_model
    import nts_pkg::*;
(
    // clock and restart pulses
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_neg_restart,
    input wire logic i_train_restart,
    // behaviour picked by the bench
    input wire logic i_answer,
    input wire logic i_fail,
    input wire logic [3:0] i_delay,
    input wire logic i_hiber,
    input wire logic i_up,
    input wire logic i_np,
    // events to the sequencer
    output nts_link_type o_link
);
    int neg_cnt = -1;
    int trn_cnt = -1;
    // silent partner never answers; protocol code scrambled outside its pulse
    // counters held in reset so unknown restart pulses cannot arm them
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            neg_cnt <= -1;
            trn_cnt <= -1;
            o_link <= '0;
        end else begin
            neg_cnt <= i_neg_restart ? int'(i_delay) : (neg_cnt >= 0 ? neg_cnt - 1 : -1);
            trn_cnt <= i_train_restart ? int'(i_delay) : (trn_cnt >= 0 ? trn_cnt - 1 : -1);
            o_link.neg_done <= i_answer && neg_cnt == 0;
            o_link.neg_proto <= (neg_cnt == 0) ? PROTO_25G : 3'h6;
            o_link.train_done <= i_answer && !i_fail && trn_cnt == 0;
            o_link.train_fail <= i_answer && i_fail && trn_cnt == 0;
            // a failed training also reports a timeout, to reach the sticky flag
            o_link.train_timeout <= i_answer && i_fail && trn_cnt == 0;
            o_link.pcs_hiber <= i_hiber;
            o_link.pcs_link_up <= i_up;
            o_link.np_exchanged <= i_np;
        end
    end
endmodule : nts_link_model
`default_nettype wire

/* File: dv/nts_seq_ctrl_test.sv */
// self-checking bench for the sequencer control block
`timescale 1ns/100ps
`default_nettype none
module nts_seq_ctrl_test
    import nts_pkg::*;
;
    // rows: address, written word, word read back
    localparam logic [79:0] ROWS [5] = '{
        {16'h00B0, 32'hFFFF_FFFF, 32'hBFFF_70F6}, {16'h00B0, 32'h0000_2002, 32'h0000_2002},
        {16'h00C0, 32'hFFFF_FFFF, 32'hFFFF_0FEF}, {16'h00C0, 32'h1234_0281, 32'h1234_0281},
        {16'h00D0, 32'hFFFF_FFFF, 32'h0000_0000}};
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    nts_req_type req = '0;
    nts_link_type lnk;
    nts_neg_ctrl_type nctl;
    logic answer = 1'b1, fail = 1'b0, hiber = 1'b0, up = 1'b1, np = 1'b0;
    logic [31:0] rdata, rd_val;
    logic rvalid, rv_seen, frs, nrs, trs, rdy, hand, halted;
    logic [3:0] rxi, txi, lpb;
    logic [2:0] proto;
    logic [7:0] stage;
    int miscompares = 0;
    int check_count = 0;
    nts_seq_ctrl #(.NEG_TIMEOUT(50), .SIM_MODE(1'b1)) i_dut (.i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst), .i_cfg_req(req), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_link(lnk), .o_rx_invert(rxi), .o_tx_invert(txi), .o_loopback(lpb),
        .o_force_rsfec(frs), .o_neg_ctrl(nctl), .o_neg_restart(nrs), .o_train_restart(trs),
        .o_proto(proto), .o_stage(stage), .o_link_ready(rdy), .o_np_handoff(hand),
        .o_halted(halted));
    nts_link_model i_partner (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_neg_restart(nrs),
        .i_train_restart(trs), .i_answer(answer), .i_fail(fail), .i_delay(4'h3),
        .i_hiber(hiber), .i_up(up), .i_np(np), .o_link(lnk));
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : tick
    // one access, strobe dropped for a cycle so back-to-back calls stay clean
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        req = '{w, ~w, a, d};
        tick(1);
        rv_seen = rvalid;
        rd_val = rdata;
        req = '0;
        tick(1);
    endtask : acc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000);
        chk(rv_seen, 32'h1);
        chk(rd_val, exp);
    endtask : rd
    // bounded wait for any stage bit in the mask
    task automatic wait_stage(input logic [7:0] m);
        int n = 0;
        while ((stage & m) == 8'h00 && n < 300) begin
            tick(1);
            n++;
        end
    endtask : wait_stage
    task automatic final_report;
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    // hang guard, several times the expected run
    initial begin
        #125000;
        miscompares++;
        final_report();
    end
    initial begin
        tick(2);
        chk(stage, 32'h0);
        i_sys_rst = 1'b0;
        rd(16'h00B0, 32'h0000_2002);
        rd(16'h00C0, 32'h1234_0281);
        foreach (ROWS[i]) begin
            acc(1'b1, ROWS[i][79:64], ROWS[i][63:32]);
            rd(ROWS[i][79:64], ROWS[i][31:0]);
        end
        chk({nctl.any_unformatted, nctl.cons_np_code}, 32'h003);
        // tx and loopback must wait for the training restart
        acc(1'b1, 16'h00B0, 32'h3FCF_2003);
        chk({txi, lpb}, 32'h00);
        rd(16'h00B0, 32'h3FCF_2002);
        wait_stage(8'hAC);
        chk({rxi, txi, lpb, stage}, 32'h111_08);
        rd(16'h00B1, 32'h0000_0801);
        // link drop while halted goes unseen until release
        acc(1'b1, 16'h00B0, 32'hBFCF_2002);
        up = 1'b0;
        tick(5);
        rd(16'h00B1, 32'h8000_0801);
        acc(1'b1, 16'h00B0, 32'h0000_2002);
        wait_stage(8'h01);
        chk(stage, 32'h01);
        up = 1'b1;
        answer = 1'b0;
        acc(1'b1, 16'h00B0, 32'h0000_6001);
        wait_stage(8'hAC);
        chk({proto, stage}, {PROTO_10G, 8'h04});
        rd(16'h00B1, 32'h0000_0403);
        answer = 1'b1;
        hiber = 1'b1;
        tick(2);
        chk(rdy, 32'h0);
        hiber = 1'b0;
        fail = 1'b1;
        acc(1'b1, 16'h00B0, 32'h0000_2003);
        wait_stage(8'h02);
        wait_stage(8'h01);
        chk(stage, 32'h01);
        rd(16'h00B1, 32'h0000_0104);
        fail = 1'b0;
        // forced four-lane protocol drives every lane
        acc(1'b1, 16'h00B0, 32'h3FC0_20C3);
        wait_stage(8'hAC);
        chk({frs, proto, rxi, txi, stage}, {1'b1, PROTO_100G_R4, 8'hFF, 8'h20});
        rd(16'h00B1, 32'h0000_2001);
        acc(1'b1, 16'h00B0, 32'h0000_20F3);
        wait_stage(8'hAC);
        chk({frs, proto, stage}, {1'b1, PROTO_100G_P2, 8'h80});
        // handoff write ignored until user pages are on, then clears on exchange
        acc(1'b1, 16'h00C1, 32'h0000_0100);
        rd(16'h00C1, 32'h0000_0000);
        acc(1'b1, 16'h00C0, 32'h1234_0285);
        acc(1'b1, 16'h00C1, 32'h0000_0100);
        rd(16'h00C1, 32'h0000_0100);
        np = 1'b1;
        tick(1);
        np = 1'b0;
        tick(2);
        rd(16'h00C1, 32'h0000_0000);
        final_report();
    end
endmodule : nts_seq_ctrl_test
`default_nettype wire
